/* verilog/icdh_dma.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Contract
// [RULE_01] software puts socket in i/o card mode
// [RULE_02] status bit reports io16 request line level
// [RULE_03] software clears io window size bits
// [RULE_04] speaker request select disables speaker output
// [RULE_05] software clears input-acknowledge control bit
// [RULE_06] dma only while global enable set
// [RULE_07] request out when card requests, fifo empty
// [RULE_08] low acknowledge lets isa dma cycles through
// [RULE_09] ordinary card cycles interleave with dma cycles
// [RULE_10] host pulses terminal count on last cycles
// [RULE_11] card-to-memory: oe low marks last read
// [RULE_12] memory-to-card: we low marks last write
// [RULE_13] two-bit select picks card request input
// [RULE_14] dma card cycle holds reg high
// [RULE_15] host keeps acknowledge low whole transfer
// [RULE_16] card width follows isa cycle width
// [RULE_17] request idle when disabled or unselected
// ----------------------------------------------------------------
module icdh_dma (
  input  logic                          i_clk,
  input  logic                          i_sys_rst,
  input  icdh_pkg::icdh_cfg_t           i_cfg,
  input  icdh_pkg::icdh_pins_t          i_pins,
  input  logic [icdh_pkg::DATA_W-1:0]   i_card_d,
  input  icdh_pkg::icdh_isa_t           i_isa,
  input  icdh_pkg::icdh_std_t           i_std,
  output icdh_pkg::icdh_card_t          o_card,
  output logic                          o_isa_ready,
  output logic                          o_drq,
  output logic                          o_dstat_req,
  output logic                          o_spkr_n,
  output logic [icdh_pkg::DATA_W-1:0]   o_isa_rdata,
  output logic                          o_isa_rvalid,
  output logic                          o_std_ready,
  output logic [icdh_pkg::DATA_W-1:0]   o_std_rdata,
  output logic                          o_std_done
);
  import icdh_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    icdh_pins_t        pin_s1;
    icdh_pins_t        pin_s2;
    icdh_pins_t        pin_s3;
    icdh_pins_t        pin_f;
    logic [DATA_W-1:0] d_s1;
    logic [DATA_W-1:0] d_s2;
    logic [DATA_W-1:0] d_s3;
    icdh_seq_t         seq;
    logic [2:0]        cnt;
    logic              cur_dma;
    icdh_cmd_t         cur_cmd;
    icdh_std_t         std_buf;
    logic              std_pend;
    logic              std_rdy;
    logic              prio_std;
    icdh_card_t        card;
    logic              drq;
    logic              dstat;
    logic              spkr_n;
    logic [DATA_W-1:0] isa_rdata;
    logic              isa_rvalid;
    logic [DATA_W-1:0] std_rdata;
    logic              std_done;
  } icdh_dma_st_t;

  icdh_dma_st_t st_ff;
  icdh_dma_st_t nxt_st;

  icdh_cmd_t    fifo_in;
  icdh_cmd_t    fifo_out;
  logic         fifo_ov;
  logic         fifo_empty;
  logic         fifo_wr_rdy;
  logic         fifo_pop;
  logic         req_on;
  logic         dma_on;
  logic         take_std;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // selected card request, active low on the pin, 1 = requesting
  function automatic logic sel_req(input logic [1:0] sel,
                                   input icdh_pins_t p);
    logic r;
    r = 1'b0;
    unique case (sel)
      SEL_INPACK: r = !p.inpack_n;
      SEL_IOIS16: r = !p.iois16_n;
      SEL_SPKR:   r = !p.spkr_n;
      SEL_NONE:   r = 1'b0;
    endcase
    return r;
  endfunction

  // chip enables for an 8- or 16-bit transfer
  function automatic logic [1:0] ce_for(input logic wide);
    return wide ? CE_WORD : CE_BYTE;
  endfunction

  // dma path open: enabled, i/o mode, input chosen, host acknowledging
  assign req_on   = sel_req(i_cfg.req_sel, st_ff.pin_f); // RULE_13
  assign dma_on   = i_cfg.dma_en && i_cfg.io_mode      // RULE_06 RULE_01
                    && (i_cfg.req_sel != SEL_NONE)
                    && !st_ff.pin_f.dack_n;            // RULE_08 RULE_15
  // strict alternation keeps a dma burst from starving ordinary cycles
  assign take_std = st_ff.std_pend && (st_ff.prio_std || !fifo_ov);
  assign fifo_pop = (st_ff.seq == SEQ_IDLE) && !take_std;

  // terminal count sampled with each accepted isa cycle
  assign fifo_in  = '{to_card: i_isa.to_card, wide: i_isa.wide,
                      tc: st_ff.pin_f.tc, data: i_isa.data}; // RULE_10

  icdh_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_en    (dma_on),
    .i_wr_valid (i_isa.valid),
    .i_wr_data  (fifo_in),
    .o_wr_ready (fifo_wr_rdy),
    .i_rd_ready (fifo_pop),
    .o_rd_valid (fifo_ov),
    .o_rd_data  (fifo_out),
    .o_empty    (fifo_empty)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // three-stage pin sync; a bit moves once stages two and three agree
    nxt_st.pin_s1 = i_pins;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.pin_s3 = st_ff.pin_s2;
    nxt_st.pin_f  = (st_ff.pin_s3 & ~(st_ff.pin_s2 ^ st_ff.pin_s3))
                  | (st_ff.pin_f & (st_ff.pin_s2 ^ st_ff.pin_s3));
    nxt_st.d_s1   = i_card_d;
    nxt_st.d_s2   = st_ff.d_s1;
    nxt_st.d_s3   = st_ff.d_s2;

    // request to isa only with an empty fifo
    nxt_st.drq    = req_on && fifo_empty && i_cfg.dma_en
                    && i_cfg.io_mode;                  // RULE_07 RULE_17
    nxt_st.dstat  = st_ff.pin_f.iois16_n;              // RULE_02
    nxt_st.spkr_n = (i_cfg.req_sel == SEL_SPKR)
                    ? 1'b1 : st_ff.pin_f.spkr_n;       // RULE_04
    nxt_st.isa_rvalid = 1'b0;
    nxt_st.std_done   = 1'b0;

    // ordinary cycle intake, one held at a time
    if (i_std.valid && st_ff.std_rdy) begin
      nxt_st.std_pend = 1'b1;
      nxt_st.std_buf  = i_std;
    end

    unique case (st_ff.seq)
      SEQ_IDLE: begin
        if (take_std) begin                            // RULE_09
          nxt_st.std_pend  = 1'b0;
          nxt_st.prio_std  = 1'b0;
          nxt_st.cur_dma   = 1'b0;
          nxt_st.card.reg_n = !(st_ff.std_buf.is_io
                                || st_ff.std_buf.is_attr);
          nxt_st.card.addr = st_ff.std_buf.addr;
          nxt_st.card.ce_n = ce_for(st_ff.std_buf.wide);
          nxt_st.card.d    = st_ff.std_buf.data;
          nxt_st.card.d_oe = st_ff.std_buf.is_write;
          nxt_st.seq       = SEQ_SETUP;
        end else if (fifo_ov) begin
          nxt_st.prio_std  = 1'b1;
          nxt_st.cur_dma   = 1'b1;
          nxt_st.cur_cmd   = fifo_out;
          nxt_st.card.reg_n = 1'b1;                    // RULE_14
          nxt_st.card.addr = '0;
          nxt_st.card.ce_n = ce_for(fifo_out.wide);    // RULE_16
          nxt_st.card.d    = fifo_out.data;
          nxt_st.card.d_oe = fifo_out.to_card;
          nxt_st.seq       = SEQ_SETUP;
        end
      end
      SEQ_SETUP: begin
        nxt_st.cnt = STROBE_CNT;
        nxt_st.seq = SEQ_STROBE;
        if (st_ff.cur_dma) begin
          nxt_st.card.iowr_n = !st_ff.cur_cmd.to_card;
          nxt_st.card.iord_n = st_ff.cur_cmd.to_card;
          nxt_st.card.oe_n   = !(!st_ff.cur_cmd.to_card
                                 && st_ff.cur_cmd.tc); // RULE_11
          nxt_st.card.we_n   = !(st_ff.cur_cmd.to_card
                                 && st_ff.cur_cmd.tc); // RULE_12
        end else if (st_ff.std_buf.is_io) begin
          nxt_st.card.iowr_n = !st_ff.std_buf.is_write;
          nxt_st.card.iord_n = st_ff.std_buf.is_write;
        end else begin
          nxt_st.card.we_n   = !st_ff.std_buf.is_write;
          nxt_st.card.oe_n   = st_ff.std_buf.is_write;
        end
      end
      SEQ_STROBE: begin
        if (st_ff.cnt == 3'h1) begin
          nxt_st.seq         = SEQ_HOLD;
          nxt_st.card.oe_n   = 1'b1;
          nxt_st.card.we_n   = 1'b1;
          nxt_st.card.iord_n = 1'b1;
          nxt_st.card.iowr_n = 1'b1;
          // byte transfers return only the low lane
          if (st_ff.cur_dma) begin
            nxt_st.isa_rdata = st_ff.cur_cmd.wide ? st_ff.d_s3
                               : {8'h00, st_ff.d_s3[7:0]};
          end else begin
            nxt_st.std_rdata = st_ff.std_buf.wide ? st_ff.d_s3
                               : {8'h00, st_ff.d_s3[7:0]};
          end
        end else begin
          nxt_st.cnt = st_ff.cnt - 3'h1;
        end
      end
      SEQ_HOLD: begin
        nxt_st.card = CARD_IDLE;
        nxt_st.seq  = SEQ_IDLE;
        if (st_ff.cur_dma) begin
          nxt_st.isa_rvalid = !st_ff.cur_cmd.to_card;
        end else begin
          nxt_st.std_done = 1'b1;
        end
      end
    endcase
    nxt_st.std_rdy = !nxt_st.std_pend;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff        <= '0;
      st_ff.pin_s1 <= PIN_RST;
      st_ff.pin_s2 <= PIN_RST;
      st_ff.pin_s3 <= PIN_RST;
      st_ff.pin_f  <= PIN_RST;
      st_ff.seq    <= SEQ_IDLE;
      st_ff.card   <= CARD_IDLE;
      st_ff.dstat  <= 1'b1;
      st_ff.spkr_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign o_card       = st_ff.card;
  assign o_isa_ready  = fifo_wr_rdy;
  assign o_drq        = st_ff.drq;
  assign o_dstat_req  = st_ff.dstat;
  assign o_spkr_n     = st_ff.spkr_n;
  assign o_isa_rdata  = st_ff.isa_rdata;
  assign o_isa_rvalid = st_ff.isa_rvalid;
  assign o_std_ready  = st_ff.std_rdy;
  assign o_std_rdata  = st_ff.std_rdata;
  assign o_std_done   = st_ff.std_done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_drq_cause;
    o_drq |-> $past(req_on) && $past(fifo_empty);
  endproperty
  a_drq_cause: assert property (p_drq_cause) // RULE_07
    else $error("request raised without cause");

  property p_drq_off;
    (!i_cfg.dma_en || i_cfg.req_sel == SEL_NONE) |=> !o_drq;
  endproperty
  a_drq_off: assert property (p_drq_off) // RULE_17
    else $error("request raised while disabled");

  property p_ack_gate;
    o_isa_ready |-> $past(dma_on) && $past(i_cfg.dma_en);
  endproperty
  a_ack_gate: assert property (p_ack_gate) // RULE_08
    else $error("isa cycles taken without acknowledge");

  property p_dma_reg;
    (st_ff.seq == SEQ_STROBE && st_ff.cur_dma)
      |-> o_card.reg_n && (o_card.iord_n != o_card.iowr_n);
  endproperty
  a_dma_reg: assert property (p_dma_reg) // RULE_14
    else $error("dma cycle without reg high");

  property p_tc_oe;
    (st_ff.seq == SEQ_SETUP && st_ff.cur_dma && !st_ff.cur_cmd.to_card)
      |=> (o_card.oe_n == !$past(st_ff.cur_cmd.tc)) && !o_card.iord_n;
  endproperty
  a_tc_oe: assert property (p_tc_oe) // RULE_11
    else $error("terminal count not on oe");

  property p_tc_we;
    (st_ff.seq == SEQ_SETUP && st_ff.cur_dma && st_ff.cur_cmd.to_card)
      |=> (o_card.we_n == !$past(st_ff.cur_cmd.tc)) && !o_card.iowr_n;
  endproperty
  a_tc_we: assert property (p_tc_we) // RULE_12
    else $error("terminal count not on we");

  property p_width;
    (st_ff.seq == SEQ_STROBE && st_ff.cur_dma)
      |-> o_card.ce_n == ce_for(st_ff.cur_cmd.wide);
  endproperty
  a_width: assert property (p_width) // RULE_16
    else $error("card width differs from isa width");

  property p_spkr;
    (i_cfg.req_sel == SEL_SPKR) |=> o_spkr_n;
  endproperty
  a_spkr: assert property (p_spkr) // RULE_04
    else $error("speaker active while used as request");

  property p_stat;
    ##1 (o_dstat_req == $past(st_ff.pin_f.iois16_n));
  endproperty
  a_stat: assert property (p_stat) // RULE_02
    else $error("status bit does not follow request line");

  property p_interleave;
    (st_ff.seq == SEQ_IDLE && st_ff.std_pend && st_ff.prio_std)
      |=> st_ff.seq == SEQ_SETUP && !st_ff.cur_dma;
  endproperty
  a_interleave: assert property (p_interleave) // RULE_09
    else $error("ordinary cycle not interleaved");

  c_drq: cover property ($rose(o_drq));
  c_tc_read: cover property (!o_card.oe_n && o_card.reg_n
                             && !o_card.iord_n);
  c_mixed: cover property (st_ff.std_pend && fifo_ov
                           && st_ff.seq == SEQ_IDLE);
  c_full: cover property (i_isa.valid && !o_isa_ready && dma_on);
endmodule

/* pkg/icdh_pkg.sv */
// ----------------------------------------------------------------
// shared constants and carriers for the card dma handshake
// ----------------------------------------------------------------
package icdh_pkg;

  // widths and depths
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned FIFO_DEPTH = 16;

  // timing: card strobe time in ns, rounded up to whole clocks
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_STROBE_NS   = 400;
  localparam int unsigned STROBE_CYC    =
    (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  STROBE_CNT    = 3'(STROBE_CYC);

  // card request input select codes
  localparam logic [1:0] SEL_NONE   = 2'h0;
  localparam logic [1:0] SEL_INPACK = 2'h1;
  localparam logic [1:0] SEL_IOIS16 = 2'h2;
  localparam logic [1:0] SEL_SPKR   = 2'h3;

  // card enables: byte lane only, both lanes, none
  localparam logic [1:0] CE_BYTE = 2'h2;
  localparam logic [1:0] CE_WORD = 2'h0;
  localparam logic [1:0] CE_OFF  = 2'h3;

  typedef struct packed {
    logic       io_mode;   // socket in i/o card interface mode
    logic       dma_en;    // global dma enable
    logic [1:0] req_sel;   // card request input select
  } icdh_cfg_t;

  // asynchronous pins, all active low except tc
  typedef struct packed {
    logic tc;
    logic dack_n;
    logic inpack_n;
    logic spkr_n;
    logic iois16_n;
  } icdh_pins_t;

  localparam logic [4:0] PIN_RST = 5'h0f;

  // isa dma cycle as decoded by the bus front end
  typedef struct packed {
    logic              valid;
    logic              to_card;  // memory to card (dma read)
    logic              wide;     // 16-bit isa cycle
    logic [DATA_W-1:0] data;
  } icdh_isa_t;

  // command word held in the fifo
  typedef struct packed {
    logic              to_card;
    logic              wide;
    logic              tc;
    logic [DATA_W-1:0] data;
  } icdh_cmd_t;

  localparam int unsigned CMD_W = $bits(icdh_cmd_t);

  // ordinary card memory or i/o cycle
  typedef struct packed {
    logic              valid;
    logic              is_io;
    logic              is_write;
    logic              is_attr;
    logic              wide;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } icdh_std_t;

  // card-side strobes, all active low, data pins as value plus drive enable
  typedef struct packed {
    logic              reg_n;
    logic              oe_n;
    logic              we_n;
    logic              iord_n;
    logic              iowr_n;
    logic [1:0]        ce_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
    logic              d_oe;
  } icdh_card_t;

  localparam icdh_card_t CARD_IDLE = '{reg_n: 1'b1, oe_n: 1'b1,
    we_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1, ce_n: CE_OFF,
    addr: '0, d: '0, d_oe: 1'b0};

  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'b0001,
    SEQ_SETUP  = 4'b0010,
    SEQ_STROBE = 4'b0100,
    SEQ_HOLD   = 4'b1000
  } icdh_seq_t;

endpackage

/* verilog/icdh_fifo.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// command fifo with registered read word
// ----------------------------------------------------------------
module icdh_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 16
) (
  input  logic             i_clk,
  input  logic             i_sys_rst,
  input  logic             i_wr_en,
  input  logic             i_wr_valid,
  input  logic [WIDTH-1:0] i_wr_data,
  output logic             o_wr_ready,
  input  logic             i_rd_ready,
  output logic             o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  output logic             o_empty
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
    logic                        rdy;
    logic                        emp;
  } icdh_fifo_st_t;

  icdh_fifo_st_t st_ff;
  icdh_fifo_st_t nxt_st;
  logic          push;
  logic          load;

  // ready is registered, so it stalls one clock early on the last slot
  assign push = i_wr_valid && st_ff.rdy;
  assign load = (st_ff.cnt != '0) && (!st_ff.ov || i_rd_ready);

  // pointer and output stage update
  always_comb begin
    nxt_st = st_ff;
    if (i_rd_ready && st_ff.ov) begin
      nxt_st.ov = 1'b0;
    end
    if (load) begin
      nxt_st.od = st_ff.mem[st_ff.rp];
      nxt_st.ov = 1'b1;
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    if (push) begin
      nxt_st.mem[st_ff.wp] = i_wr_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    nxt_st.cnt = (AW+1)'(st_ff.cnt + push - load);
    nxt_st.rdy = i_wr_en && (nxt_st.cnt < (AW+1)'(DEPTH - 1));
    nxt_st.emp = (nxt_st.cnt == '0) && !nxt_st.ov && !push;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff     <= '0;
      st_ff.emp <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_wr_ready = st_ff.rdy;
  assign o_rd_valid = st_ff.ov;
  assign o_rd_data  = st_ff.od;
  assign o_empty    = st_ff.emp;
endmodule

/* sim/icdh_card_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// dma-capable card: answers reads, counts dma cycles
// ----------------------------------------------------------------
module icdh_card_model #(
  parameter logic [15:0] RD_WORD = 16'ha5c3
) (
  input  logic                          i_clk,
  input  icdh_pkg::icdh_card_t          i_card,
  output logic [icdh_pkg::DATA_W-1:0]   o_d,
  output logic [7:0]                    o_dma_cnt
);
  import icdh_pkg::*;
  logic              rd_strobe;
  logic              io_strobe;
  logic              io_prev_ff = 1'b0;
  logic [7:0]        cnt_ff     = 8'h00;
  logic [DATA_W-1:0] junk_ff    = 16'h0f0f;

  // both lanes carry the word, the host picks the lane it asked for
  assign rd_strobe = !i_card.iord_n || !i_card.oe_n;
  assign io_strobe = !i_card.iord_n || !i_card.iowr_n;
  // released bus flips every cycle so a stale capture cannot match
  assign o_d       = rd_strobe ? RD_WORD : junk_ff;
  assign o_dma_cnt = cnt_ff;

  // reg high with an i/o strobe is the dma acknowledge to the card
  always_ff @(posedge i_clk) begin
    junk_ff    <= ~junk_ff;
    io_prev_ff <= io_strobe;
    if (io_strobe && !io_prev_ff && i_card.reg_n) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule

/* sim/isa_card_dma_handshake_test.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// self-checking bench for the card dma handshake
// ----------------------------------------------------------------
module isa_card_dma_handshake_test;
  import icdh_pkg::*;
  localparam logic [15:0] RD_WORD = 16'ha5c3;
  logic              i_clk     = 1'b0;
  logic              i_sys_rst = 1'b1;
  icdh_cfg_t         cfg;
  icdh_pins_t        pins;
  icdh_isa_t         isa;
  icdh_std_t         std_req;
  icdh_card_t        card;
  logic [DATA_W-1:0] card_d;
  logic [DATA_W-1:0] isa_rdata;
  logic [DATA_W-1:0] std_rdata;
  logic              isa_ready;
  logic              drq;
  logic              dstat_req;
  logic              spkr_n;
  logic              isa_rvalid;
  logic              std_ready;
  logic              std_done;
  logic [7:0]        dma_cnt;
  int                failures    = 0;
  int                comparisons = 0;

  // 10 MHz core clock
  always #50 i_clk = ~i_clk;

  icdh_dma dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg(cfg),
    .i_pins(pins), .i_card_d(card_d), .i_isa(isa), .i_std(std_req),
    .o_card(card), .o_isa_ready(isa_ready), .o_drq(drq),
    .o_dstat_req(dstat_req), .o_spkr_n(spkr_n),
    .o_isa_rdata(isa_rdata), .o_isa_rvalid(isa_rvalid),
    .o_std_ready(std_ready), .o_std_rdata(std_rdata),
    .o_std_done(std_done));

  icdh_card_model #(.RD_WORD(RD_WORD)) card_m (.i_clk(i_clk),
    .i_card(card), .o_d(card_d), .o_dma_cnt(dma_cnt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs move 10 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #10;
    end
  endtask

  // low bits 3..0 pull active-low pins down, bit 4 raises tc;
  // window size and input-ack bits are software's, outside this block
  task automatic setup(input logic [1:0] sel, input logic [4:0] low);
    cfg  = '{io_mode: 1'b1, dma_en: 1'b1,
             req_sel: sel};
    pins = PIN_RST ^ low;
    tick(6);
  endtask

  // valid held until the edge that sees ready
  task automatic push(input logic to_card, wide, input logic [15:0] d);
    int n = 0;
    isa = '{valid: 1'b1, to_card: to_card, wide: wide, data: d};
    while (!isa_ready && n < 40) begin
      tick(1);
      n++;
    end
    tick(1);
    isa.valid = 1'b0;
    chk(16'(n < 40), 16'h0001);
    tick(1); // one idle edge before any next request
  endtask

  task automatic push_std(input logic io, wr, attr);
    int n = 0;
    std_req = '{valid: 1'b1, is_io: io, is_write: wr, is_attr: attr,
      wide: 1'b1, addr: 12'h0a5, data: 16'h3c5a};
    while (!std_ready && n < 40) begin
      tick(1);
      n++;
    end
    tick(1);
    std_req.valid = 1'b0;
    chk(16'(n < 40), 16'h0001);
  endtask

  task automatic wait_strobe(output icdh_card_t c);
    int n = 0;
    while (card.iord_n && card.iowr_n && card.oe_n && card.we_n
           && n < 40) begin
      tick(1);
      n++;
    end
    chk(16'(n < 40), 16'h0001);
    c = card;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // each select code against each request line; pin bits 2,0,1
  task automatic t_request();
    logic [4:0] line_mask [4] = '{5'h00, 5'h04, 5'h01, 5'h02};
    for (int s = 0; s < 4; s++) begin
      for (int l = 1; l < 4; l++) begin
        setup(2'(s), line_mask[l]);
        chk(16'(drq), 16'(s == l));
        chk(16'(dstat_req), 16'(l != 2));
        chk(16'(spkr_n), 16'(l != 3 || s == 3));
      end
    end
    // acknowledge held low so only enable, i/o mode or select can refuse cycles
    setup(SEL_IOIS16, 5'h09);
    cfg.dma_en = 1'b0;
    tick(6);
    chk(16'(drq), 16'h0000);
    chk(16'(isa_ready), 16'h0000);
    cfg = '{io_mode: 1'b0, dma_en: 1'b1, req_sel: SEL_IOIS16};
    tick(6);
    chk(16'(drq | isa_ready), 16'h0000);
    cfg = '{io_mode: 1'b1, dma_en: 1'b1, req_sel: SEL_NONE};
    pins = PIN_RST & ~5'h08;
    tick(6);
    chk(16'(drq | isa_ready), 16'h0000);
  endtask

  task automatic t_ack_gate();
    setup(SEL_IOIS16, 5'h01);
    chk(16'(isa_ready), 16'h0000);
    pins.dack_n = 1'b0;
    tick(6);
    chk(16'(isa_ready), 16'h0001);
  endtask

  // one dma transfer either way, tc raised ahead of the take
  task automatic t_dma(input logic to_card, wide, tc);
    icdh_card_t c;
    logic [15:0] lane;
    int n = 0;
    lane = wide ? 16'hffff : 16'h00ff;
    setup(SEL_IOIS16, {tc, 4'h9});
    push(to_card, wide, 16'h6b2d);
    wait_strobe(c);
    chk(16'(c.reg_n), 16'h0001);
    chk(16'(c.ce_n), 16'(wide ? CE_WORD : CE_BYTE));
    chk({c.iord_n, c.iowr_n}, 16'(to_card ? 2'b10 : 2'b01));
    if (to_card) begin
      chk({c.we_n, c.oe_n}, {14'h0, !tc, 1'b1});
      chk(c.d & lane, 16'h6b2d & lane);
      chk(16'(c.d_oe), 16'h0001);
    end else begin
      chk({c.we_n, c.oe_n}, {14'h0, 1'b1, !tc});
      while (!isa_rvalid && n < 40) begin
        tick(1);
        n++;
      end
      chk(16'(c.d_oe), 16'h0000);
      chk(16'(isa_rvalid), 16'h0001);
      chk(isa_rdata, RD_WORD & lane);
    end
    tick(12);
  endtask

  // ordinary cycles: io read, attribute write, common read
  task automatic t_std();
    logic [4:0] exp_str [3] = '{5'b01101, 5'b01011, 5'b10111};
    icdh_card_t c;
    int n;
    setup(SEL_NONE, 5'h00);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      push_std(k == 0, k == 1, k == 1);
      wait_strobe(c);
      chk({c.reg_n, c.oe_n, c.we_n, c.iord_n, c.iowr_n},
          16'(exp_str[k]));
      while (!std_done && n < 40) begin
        tick(1);
        n++;
      end
      chk(16'(std_done), 16'h0001);
      chk(16'(c.addr), 16'h00a5);
      if (k != 1) chk(std_rdata, RD_WORD);
      tick(2);
    end
  endtask

  // dma burst with an ordinary read slipped in between
  task automatic t_interleave();
    logic [7:0] start;
    int n = 0;
    setup(SEL_IOIS16, 5'h09);
    start = dma_cnt;
    push(1'b1, 1'b1, 16'h1111);
    push(1'b1, 1'b1, 16'h2222);
    push_std(1'b1, 1'b0, 1'b0);
    push(1'b1, 1'b1, 16'h3333);
    while (!std_done && n < 80) begin
      tick(1);
      n++;
    end
    chk(16'(std_done), 16'h0001);
    chk(std_rdata, RD_WORD);
    tick(40);
    chk(16'(dma_cnt - start), 16'h0003);
  endtask

  // fill the fifo until it refuses, then drain it
  task automatic t_fill();
    logic [7:0] start;
    int acc = 0;
    int n = 0;
    setup(SEL_IOIS16, 5'h09);
    start = dma_cnt;
    isa = '{valid: 1'b1, to_card: 1'b1, wide: 1'b1, data: 16'h7e81};
    while (n < 60 && !(acc > 0 && !isa_ready)) begin
      if (isa_ready) acc++;
      tick(1);
      n++;
    end
    tick(1); // one refused edge with valid still up
    isa.valid = 1'b0;
    chk(16'(acc >= 15), 16'h0001);
    chk(16'(drq), 16'h0000);
    n = 0;
    while (dma_cnt - start != 8'(acc) && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(dma_cnt - start), 16'(acc));
    tick(12);
    chk(16'(drq), 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cfg     = '0;
    pins    = PIN_RST;
    isa     = '0;
    std_req = '0;
    tick(12);
    i_sys_rst = 1'b0;
    chk({card.reg_n, card.oe_n, card.we_n, card.iord_n, card.iowr_n,
         card.ce_n, card.d_oe}, 16'h00fe);
    chk({drq, spkr_n, isa_ready}, 16'h0002);
    tick(2);
    chk(16'(std_ready), 16'h0001);
    t_request();
    t_ack_gate();
    for (int m = 0; m < 8; m++) begin
      t_dma(m[2], m[1], m[0]);
    end
    t_std();
    t_interleave();
    t_fill();
    report_and_stop();
  end

  // whole run is under a thousand cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
endmodule
